// ---- hdl/uart9_pkg.sv ----
// Purpose: Shared constants, register map and types of the nine-bit UART.
// Assumes: 32-bit APB, one aligned word per register.
// Notes: Offsets are byte addresses.
package uart9_pkg;

  // ---------------------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------------------
  localparam logic [7:0] OFF_SERIAL_CONTROL = 8'h00;
  localparam logic [7:0] OFF_SERIAL_BUFFER = 8'h04;
  localparam logic [7:0] OFF_SLAVE_ADDRESS = 8'h08;
  localparam logic [7:0] OFF_SLAVE_ADDRESS_MASK = 8'h0C;
  localparam logic [7:0] OFF_STATUS = 8'h10;

  // Control register layout, low byte of the word.
  typedef struct packed {
    logic rx_done_flag;
    logic tx_done_flag;
    logic rx_ninth_bit;
    logic tx_ninth_bit;
    logic multiproc_filter_en;
    logic rx_enable;
    logic fast_rate;
    logic mode3_sel;
  } serial_control_type;

  localparam serial_control_type CONTROL_RESET = '0;
  localparam logic [7:0] ADDRESS_RESET = 8'h00;

  // ---------------------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------------------
  localparam logic [3:0] DIV_LAST = 4'hF;
  localparam logic [3:0] SAMPLE_FIRST = 4'h7;
  localparam logic [3:0] SAMPLE_MID = 4'h8;
  localparam logic [3:0] SAMPLE_LAST = 4'h9;
  localparam logic [8:0] RX_SHIFT_INIT = 9'h1FF;

  typedef enum logic [1:0] {TX_IDLE, TX_START, TX_DATA} tx_state_type;
  typedef enum logic [1:0] {RX_IDLE, RX_FRAME, RX_HOLD} rx_state_type;

endpackage

// ---- hdl/nine_bit_uart.sv ----
// Purpose: Eleven-bit frame UART (modes 2 and 3) with address recognition.
// Assumes: APB register access; serial_rx_i synchronous to clk_sys_i.
// Notes: timer_ovf_i is a one-cycle pulse per timer overflow.
//
// Behaviour
// - Frame is start low, eight data LSB first, ninth bit, stop high.
// - Transmitted ninth bit equals the software transmit ninth-bit value.
// - Mode 2 bit rate is clock/16 or clock/32 by software choice.
// - Mode 3 bit rate derives from timer overflow events.
// - Buffer write loads ninth bit into shifter and requests transmission.
// - Sending starts after next divide-by-16 rollover, not at the write.
// - Start bit first; shifter output a bit later; first shift after that.
// - First shift inserts the stop one; later shifts insert zeros.
// - Ninth bit at output with stop beside: last shift, end, set done.
// - Sample 16x; falling edge resets counter and loads all ones.
// - Sample at states 7, 8, 9 and take the two-of-three majority.
// - Non-zero start bit resets receiver to hunting for a falling edge.
// - Nine-bit shifter; start bit at left end triggers final shift.
// - Load only if receive-done clear and filter off or ninth bit one.
// - Failing either load condition discards the frame; flags are left unchanged.
// - Loaded frame puts ninth bit in flag, eight bits in buffer.
// - One bit time after final shift, resume hunting for falling edge.
// - Filter bit affects only the nine-bit modes present here.
// - With filter on, accept only ninth-bit-one frames matching an address.
// - Given address: bits where mask is one must equal slave address.
// - Broadcast address is address OR mask; zeros there are don't-care.
// - Reset clears slave address and mask to zero.
//
// The register addresses and the APB slave port were left to the implementer.
`timescale 1ns/1ps

module nine_bit_uart (
  // Clock, reset and enable
  input wire logic clk_sys_i,
  input wire logic resetn_i,
  input wire logic ce_i,
  // APB slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // Baud source and serial line
  input wire logic timer_ovf_i,
  input wire logic serial_rx_i,
  output logic serial_tx_o,
  // Interrupt request
  output logic irq_o
);

  // ---------------------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------------------
  uart9_pkg::serial_control_type serial_control_reg;
  logic [7:0] serial_buffer_reg;
  logic [7:0] slave_address_reg;
  logic [7:0] slave_address_mask_reg;
  logic [31:0] prdata_reg;
  logic pready_reg;
  logic pslverr_reg;
  logic irq_reg;

  logic half_reg;
  logic [3:0] tx_div_reg;
  logic [3:0] rx_div_reg;
  uart9_pkg::tx_state_type tx_state_reg;
  logic tx_pending_reg;
  logic [9:0] tx_shift_reg;
  logic tx_first_reg;
  logic tx_line_reg;
  uart9_pkg::rx_state_type rx_state_reg;
  logic [8:0] rx_shift_reg;
  logic rx_line_reg;
  logic [1:0] rx_votes_reg;

  // ---------------------------------------------------------------------------
  // Bus decode
  // ---------------------------------------------------------------------------
  logic acc_done;
  logic wr_en;
  logic rd_en;
  logic hit;
  logic wr_buffer;
  logic wr_control;
  logic tx_set;
  logic rx_set;
  logic rx_load;
  logic [7:0] rx_byte;

  assign acc_done = psel_i && penable_i && pready_reg;
  assign wr_en = acc_done && pwrite_i;
  assign rd_en = psel_i && penable_i && !pready_reg && !pwrite_i;
  assign hit = (paddr_i == uart9_pkg::OFF_SERIAL_CONTROL) ||
               (paddr_i == uart9_pkg::OFF_SERIAL_BUFFER) ||
               (paddr_i == uart9_pkg::OFF_SLAVE_ADDRESS) ||
               (paddr_i == uart9_pkg::OFF_SLAVE_ADDRESS_MASK) ||
               (paddr_i == uart9_pkg::OFF_STATUS);
  assign wr_buffer = wr_en && (paddr_i == uart9_pkg::OFF_SERIAL_BUFFER);
  assign wr_control = wr_en && (paddr_i == uart9_pkg::OFF_SERIAL_CONTROL);

  // The answer is registered, so every access takes exactly one wait state while ce_i stays high; a low ce_i stalls it longer.
  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg <= 32'h0000_0000;
    end else if (ce_i) begin
      pready_reg <= psel_i && penable_i && !pready_reg;
      pslverr_reg <= psel_i && penable_i && !pready_reg && !hit;
      if (rd_en) begin
        case (paddr_i)
          uart9_pkg::OFF_SERIAL_CONTROL: prdata_reg <= {24'h00_0000, serial_control_reg};
          uart9_pkg::OFF_SERIAL_BUFFER: prdata_reg <= {24'h00_0000, serial_buffer_reg};
          uart9_pkg::OFF_SLAVE_ADDRESS: prdata_reg <= {24'h00_0000, slave_address_reg};
          uart9_pkg::OFF_SLAVE_ADDRESS_MASK: prdata_reg <= {24'h00_0000, slave_address_mask_reg};
          uart9_pkg::OFF_STATUS: begin
            prdata_reg <= {29'h0000_0000, tx_pending_reg, tx_state_reg != uart9_pkg::TX_IDLE,
                           rx_state_reg != uart9_pkg::RX_IDLE};
          end
          default: prdata_reg <= 32'h0000_0000;
        endcase
      end else begin
        prdata_reg <= 32'h0000_0000;
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Address registers
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      slave_address_reg <= uart9_pkg::ADDRESS_RESET;
      slave_address_mask_reg <= uart9_pkg::ADDRESS_RESET;
    end else if (ce_i && wr_en) begin
      if (paddr_i == uart9_pkg::OFF_SLAVE_ADDRESS) begin
        slave_address_reg <= pwdata_i[7:0];
      end
      if (paddr_i == uart9_pkg::OFF_SLAVE_ADDRESS_MASK) begin
        slave_address_mask_reg <= pwdata_i[7:0];
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Control register and flags
  // ---------------------------------------------------------------------------
  // Hardware setting a done flag wins over a software clear in the same cycle.
  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      serial_control_reg <= uart9_pkg::CONTROL_RESET;
    end else if (ce_i) begin
      if (wr_control) begin
        serial_control_reg <= pwdata_i[7:0];
      end
      if (tx_set) begin
        serial_control_reg.tx_done_flag <= 1'b1;
      end
      if (rx_load) begin
        serial_control_reg.rx_done_flag <= 1'b1;
        serial_control_reg.rx_ninth_bit <= vote;
      end
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      irq_reg <= 1'b0;
    end else if (ce_i) begin
      irq_reg <= serial_control_reg.tx_done_flag || serial_control_reg.rx_done_flag;
    end
  end

  // ---------------------------------------------------------------------------
  // Sample tick
  // ---------------------------------------------------------------------------
  // The tick runs at sixteen times the bit rate; the slow choice halves it.
  logic base_tick;
  logic tick;

  assign base_tick = serial_control_reg.mode3_sel ? timer_ovf_i : 1'b1;
  assign tick = base_tick && (serial_control_reg.fast_rate || half_reg);

  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      half_reg <= 1'b0;
    end else if (ce_i && base_tick) begin
      half_reg <= !half_reg;
    end
  end

  // ---------------------------------------------------------------------------
  // Transmitter
  // ---------------------------------------------------------------------------
  logic tx_roll;

  assign tx_roll = tick && (tx_div_reg == uart9_pkg::DIV_LAST);
  assign tx_set = tx_roll && (tx_state_reg == uart9_pkg::TX_DATA) && !tx_first_reg &&
                  (tx_shift_reg[9:2] == 8'h00) && tx_shift_reg[1];

  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      tx_div_reg <= 4'h0;
    end else if (ce_i && tick) begin
      tx_div_reg <= tx_div_reg + 4'h1;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      tx_pending_reg <= 1'b0;
      tx_shift_reg <= 10'h000;
    end else if (ce_i) begin
      if (wr_buffer) begin
        tx_pending_reg <= 1'b1;
        tx_shift_reg <= {1'b0, serial_control_reg.tx_ninth_bit, pwdata_i[7:0]};
      end else if (tx_roll && tx_state_reg == uart9_pkg::TX_IDLE) begin
        tx_pending_reg <= 1'b0;
      end else if (tx_roll && tx_state_reg == uart9_pkg::TX_DATA) begin
        if (tx_first_reg) begin
          tx_shift_reg <= {1'b0, 1'b1, tx_shift_reg[8:1]};
        end else begin
          tx_shift_reg <= {1'b0, tx_shift_reg[9:1]};
        end
      end
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      tx_state_reg <= uart9_pkg::TX_IDLE;
      tx_first_reg <= 1'b0;
    end else if (ce_i && tx_roll) begin
      case (tx_state_reg)
        uart9_pkg::TX_IDLE: begin
          if (tx_pending_reg) begin
            tx_state_reg <= uart9_pkg::TX_START;
          end
        end
        uart9_pkg::TX_START: begin
          tx_state_reg <= uart9_pkg::TX_DATA;
          tx_first_reg <= 1'b1;
        end
        uart9_pkg::TX_DATA: begin
          tx_first_reg <= 1'b0;
          if (tx_set) begin
            tx_state_reg <= uart9_pkg::TX_IDLE;
          end
        end
        default: tx_state_reg <= uart9_pkg::TX_IDLE;
      endcase
    end
  end

  // The line is idle high, so the stop bit simply stays after sending ends.
  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      tx_line_reg <= 1'b1;
    end else if (ce_i) begin
      case (tx_state_reg)
        uart9_pkg::TX_START: tx_line_reg <= 1'b0;
        uart9_pkg::TX_DATA: tx_line_reg <= tx_shift_reg[0];
        default: tx_line_reg <= 1'b1;
      endcase
    end
  end

  // ---------------------------------------------------------------------------
  // Receiver
  // ---------------------------------------------------------------------------
  logic rx_fall;
  logic vote_point;
  logic vote;
  logic given_match;
  logic bcast_match;
  logic [7:0] bcast_addr;

  assign rx_fall = tick && rx_line_reg && !serial_rx_i;
  assign vote_point = tick && (rx_div_reg == uart9_pkg::SAMPLE_LAST);
  assign vote = (rx_votes_reg[0] && rx_votes_reg[1]) ||
                (serial_rx_i && (rx_votes_reg[0] || rx_votes_reg[1]));

  // The first eight bits arrived least significant first from the right.
  always_comb begin
    rx_byte = 8'h00;
    for (int i = 0; i < 8; i++) begin
      rx_byte[i] = rx_shift_reg[7 - i];
    end
  end

  assign given_match = ((rx_byte ^ slave_address_reg) & slave_address_mask_reg) == 8'h00;
  assign bcast_addr = slave_address_reg | slave_address_mask_reg;
  assign bcast_match = (~rx_byte & bcast_addr) == 8'h00;
  assign rx_set = vote_point && (rx_state_reg == uart9_pkg::RX_FRAME) && !rx_shift_reg[8];
  // Only the nine-bit modes exist here, so the filter always means address mode.
  assign rx_load = rx_set && !serial_control_reg.rx_done_flag &&
                   (!serial_control_reg.multiproc_filter_en ||
                    (vote && (given_match || bcast_match)));

  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      rx_line_reg <= 1'b1;
    end else if (ce_i && tick) begin
      rx_line_reg <= serial_rx_i;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      rx_div_reg <= 4'h0;
      rx_votes_reg <= 2'b00;
    end else if (ce_i && tick) begin
      if (rx_state_reg == uart9_pkg::RX_IDLE && rx_fall) begin
        rx_div_reg <= 4'h0;
      end else begin
        rx_div_reg <= rx_div_reg + 4'h1;
      end
      if (rx_div_reg == uart9_pkg::SAMPLE_FIRST) begin
        rx_votes_reg[0] <= serial_rx_i;
      end
      if (rx_div_reg == uart9_pkg::SAMPLE_MID) begin
        rx_votes_reg[1] <= serial_rx_i;
      end
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      rx_state_reg <= uart9_pkg::RX_IDLE;
      rx_shift_reg <= uart9_pkg::RX_SHIFT_INIT;
    end else if (ce_i) begin
      case (rx_state_reg)
        uart9_pkg::RX_IDLE: begin
          if (rx_fall && serial_control_reg.rx_enable) begin
            rx_state_reg <= uart9_pkg::RX_FRAME;
            rx_shift_reg <= uart9_pkg::RX_SHIFT_INIT;
          end
        end
        uart9_pkg::RX_FRAME: begin
          if (vote_point) begin
            if (rx_shift_reg == uart9_pkg::RX_SHIFT_INIT && vote) begin
              rx_state_reg <= uart9_pkg::RX_IDLE;
            end else begin
              rx_shift_reg <= {rx_shift_reg[7:0], vote};
              if (!rx_shift_reg[8]) begin
                rx_state_reg <= uart9_pkg::RX_HOLD;
              end
            end
          end
        end
        uart9_pkg::RX_HOLD: begin
          if (vote_point) begin
            rx_state_reg <= uart9_pkg::RX_IDLE;
          end
        end
        default: rx_state_reg <= uart9_pkg::RX_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      serial_buffer_reg <= 8'h00;
    end else if (ce_i && rx_load) begin
      serial_buffer_reg <= rx_byte;
    end
  end

  assign prdata_o = prdata_reg;
  assign pready_o = pready_reg;
  assign pslverr_o = pslverr_reg;
  assign serial_tx_o = tx_line_reg;
  assign irq_o = irq_reg;

endmodule // nine_bit_uart

// ---- bench/uart9_sva.sv ----
// Purpose: Port-level assertions for the nine-bit UART.
// Assumes: One clock, synchronous active-low reset.
// Notes: Bound to every nine_bit_uart instance.
`timescale 1ns/1ps

module uart9_sva (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic resetn_i,
  input wire logic ce_i,
  // Bus
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [31:0] prdata_o,
  input wire logic pready_o,
  input wire logic pslverr_o,
  // Serial and interrupt
  input wire logic timer_ovf_i,
  input wire logic serial_rx_i,
  input wire logic serial_tx_o,
  input wire logic irq_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!resetn_i);
  logic first_acc;
  logic ctrl_rd;
  assign first_acc = psel_i && penable_i && !pready_o && ce_i;
  assign ctrl_rd = pready_o && !pwrite_i && paddr_i == 8'h00;

  a_pready_wait: assert property (first_acc |=> pready_o)
    else $error("pready missing after one wait state");
  a_pready_once: assert property (pready_o |=> !pready_o)
    else $error("pready held past one cycle");
  a_rdata_idle: assert property (!pready_o |-> prdata_o == 32'h00000000)
    else $error("read data not zero outside answer");
  a_err_with_ready: assert property (pslverr_o |-> pready_o)
    else $error("error without ready");
  a_unmapped_err: assert property (first_acc && paddr_i > 8'h10 |=> pslverr_o)
    else $error("unmapped access not refused");
  a_no_select: assert property (!psel_i |=> !pready_o)
    else $error("answer without select");
  // Shortest bit lasts sixteen clocks, so half of it must stay put.
  a_bit_hold: assert property ($changed(serial_tx_o) |=> $stable(serial_tx_o) [*8])
    else $error("transmit bit shorter than allowed");
  a_irq_flag: assert property (ctrl_rd && (prdata_o[7] || prdata_o[6]) |-> ##[0:2] irq_o)
    else $error("irq not raised for set flag");
  a_reset_idle: assert property ($rose(resetn_i) |-> serial_tx_o && !irq_o && !pready_o)
    else $error("outputs not idle after reset");
  a_freeze_hold: assert property (!ce_i |=> $stable(serial_tx_o) && $stable(irq_o) &&
                                  $stable(pready_o) && $stable(prdata_o))
    else $error("outputs moved while clock enable low");

  cover property ($fell(serial_tx_o));
  cover property ($rose(irq_o));
  cover property (pslverr_o);
  cover property (!ce_i && psel_i && penable_i);
endmodule // uart9_sva

bind nine_bit_uart uart9_sva uart9_sva_i (.clk_sys_i(clk_sys_i), .resetn_i(resetn_i),
  .ce_i(ce_i), .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
  .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
  .pslverr_o(pslverr_o), .timer_ovf_i(timer_ovf_i), .serial_rx_i(serial_rx_i),
  .serial_tx_o(serial_tx_o), .irq_o(irq_o));

// ---- bench/uart9_partner.sv ----
// Purpose: Far-end UART on the shared serial line.
// Assumes: Bit time of bit_clks_i system clocks, set by the bench.
// Notes: Receiver samples mid-bit after each falling edge that it sees while idle.
`timescale 1ns/1ps

module uart9_partner (
  // Clock, bit time and line
  input wire logic clk_sys_i,
  input wire logic [6:0] bit_clks_i,
  input wire logic line_in_i,
  output logic line_out_o
);
  logic [10:0] frame_bits = '1;
  int frame_count = 0;
  initial line_out_o = 1'b1;

  task automatic send_frame(input logic [7:0] data, input logic ninth);
    logic [10:0] bits;
    bits = {1'b1, ninth, data, 1'b0};
    for (int i = 0; i < 11; i++) begin
      @(posedge clk_sys_i);
      line_out_o <= bits[i];
      repeat (bit_clks_i - 7'h01) @(posedge clk_sys_i);
    end
  endtask

  task automatic send_glitch(input int len);
    @(posedge clk_sys_i);
    line_out_o <= 1'b0;
    repeat (len) @(posedge clk_sys_i);
    line_out_o <= 1'b1;
  endtask

  always begin
    @(negedge line_in_i);
    repeat (bit_clks_i / 2) @(posedge clk_sys_i);
    for (int i = 0; i < 11; i++) begin
      frame_bits[i] = line_in_i;
      repeat (bit_clks_i) @(posedge clk_sys_i);
    end
    frame_count++;
  end
endmodule // uart9_partner

// ---- bench/testbench.sv ----
// Purpose: Self-checking bench for the nine-bit UART.
// Assumes: Timer overflow pulses every second clock; partner bit time set here.
// Notes: Registers reached over APB; far end is uart9_partner.
`timescale 1ns/1ps

module testbench;
  localparam logic [7:0] CTRL = uart9_pkg::OFF_SERIAL_CONTROL;
  localparam logic [7:0] BUF = uart9_pkg::OFF_SERIAL_BUFFER;
  logic clk_sys_i = 1'b0;
  logic resetn_i = 1'b0;
  logic ce_i = 1'b1;
  logic psel_i = 1'b0;
  logic penable_i = 1'b0;
  logic pwrite_i = 1'b0;
  logic [7:0] paddr_i = 8'h00;
  logic [31:0] pwdata_i = 32'h00000000;
  logic timer_ovf_i = 1'b0;
  logic serial_rx_i;
  logic serial_tx_o;
  logic [31:0] prdata_o;
  logic pready_o;
  logic pslverr_o;
  logic irq_o;
  logic [31:0] rd;
  logic rd_err;
  logic [6:0] bit_clks = 7'h10;
  int err_count = 0;
  int tests_run = 0;

  always #25 clk_sys_i = ~clk_sys_i;

  // Free-running overflow pulse; mode 2 ignores it, mode 3 gets a tick every two clocks.
  always @(posedge clk_sys_i) begin
    timer_ovf_i <= !timer_ovf_i;
  end

  nine_bit_uart nine_bit_uart_i (.clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .ce_i(ce_i),
    .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
    .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
    .timer_ovf_i(timer_ovf_i), .serial_rx_i(serial_rx_i), .serial_tx_o(serial_tx_o),
    .irq_o(irq_o));
  uart9_partner uart9_partner_i (.clk_sys_i(clk_sys_i), .bit_clks_i(bit_clks),
    .line_in_i(serial_tx_o),
    .line_out_o(serial_rx_i));

  task automatic give_verdict();
    if (err_count == 0 && tests_run > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic check_word(input string name, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask

  // Request is held until pready is seen at a rising edge.
  task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] wdata);
    @(posedge clk_sys_i);
    psel_i <= 1'b1;
    penable_i <= 1'b0;
    pwrite_i <= wr;
    paddr_i <= addr;
    pwdata_i <= wdata;
    @(posedge clk_sys_i);
    penable_i <= 1'b1;
    @(posedge clk_sys_i);
    while (pready_o !== 1'b1) @(posedge clk_sys_i);
    rd = prdata_o;
    rd_err = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask

  task automatic test_reset_values();
    apb(0, uart9_pkg::OFF_SLAVE_ADDRESS, 0);
    check_word("slave address", 32'h00000000, rd);
    apb(0, uart9_pkg::OFF_SLAVE_ADDRESS_MASK, 0);
    check_word("address mask", 32'h00000000, rd);
    apb(1, 8'h20, 32'h000000FF);
    check_word("unmapped error", 32'h00000001, {31'h0, rd_err});
    // A low clock enable in mid access must stall the answer, not lose it.
    apb(1, uart9_pkg::OFF_SLAVE_ADDRESS, 32'h0000005C);
    fork
      apb(0, uart9_pkg::OFF_SLAVE_ADDRESS, 0);
      begin
        repeat (2) @(posedge clk_sys_i);
        ce_i <= 1'b0;
        repeat (6) @(posedge clk_sys_i);
        ce_i <= 1'b1;
      end
    join
    check_word("frozen read", 32'h0000005C, rd);
  endtask

  task automatic test_tx();
    logic [7:0] dat;
    logic [31:0] ctl;
    int prev;
    for (int k = 0; k < 2; k++) begin
      dat = k ? 8'h3C : 8'hA5;
      ctl = k ? 32'h06 : 32'h16;
      apb(1, CTRL, ctl);
      prev = uart9_partner_i.frame_count;
      apb(1, BUF, {24'h0, dat});
      for (int n = 0; n < 600 && uart9_partner_i.frame_count == prev; n++) begin
        @(posedge clk_sys_i);
      end
      check_word("tx frame", {21'h0, 1'b1, ctl[4], dat, 1'b0}, {21'h0, uart9_partner_i.frame_bits});
      apb(0, CTRL, 0);
      check_word("tx done", ctl | 32'h40, rd);
      check_word("irq tx", 32'h1, {31'h0, irq_o});
    end
  endtask

  task automatic test_rx();
    apb(1, CTRL, 32'h06);
    uart9_partner_i.send_glitch(4);
    repeat (40) @(posedge clk_sys_i);
    apb(0, CTRL, 0);
    check_word("false start", 32'h06, rd);
    uart9_partner_i.send_frame(8'h5A, 1'b1);
    uart9_partner_i.send_frame(8'h33, 1'b0);
    apb(0, BUF, 0);
    check_word("rx kept", 32'h5A, rd);
    apb(0, CTRL, 0);
    check_word("rx flags", 32'hA6, rd);
    check_word("irq rx", 32'h1, {31'h0, irq_o});
    apb(1, CTRL, 32'h06);
    uart9_partner_i.send_frame(8'hC3, 1'b0);
    apb(0, BUF, 0);
    check_word("rx again", 32'hC3, rd);
    apb(0, CTRL, 0);
    check_word("rx ninth zero", 32'h86, rd);
  endtask

  task automatic test_filter();
    logic [9:0] cases [4] = '{10'h3C2, 10'h0C0, 10'h101, 10'h3FF};
    logic [7:0] last;
    last = 8'hC3;
    apb(1, uart9_pkg::OFF_SLAVE_ADDRESS, 32'hC0);
    apb(1, uart9_pkg::OFF_SLAVE_ADDRESS_MASK, 32'hFD);
    for (int k = 0; k < 4; k++) begin
      apb(1, CTRL, 32'h0E);
      uart9_partner_i.send_frame(cases[k][7:0], cases[k][8]);
      if (cases[k][9]) last = cases[k][7:0];
      apb(0, CTRL, 0);
      check_word("filter flags", cases[k][9] ? 32'hAE : 32'h0E, rd);
      apb(0, BUF, 0);
      check_word("filter data", {24'h0, last}, rd);
    end
  endtask

  // Slow mode 2 and timer-paced mode 3 both give 32 clocks per bit here.
  task automatic test_rates();
    logic [31:0] ctl;
    logic [7:0] dat;
    int prev;
    for (int k = 0; k < 2; k++) begin
      ctl = k ? 32'h07 : 32'h04;
      dat = k ? 8'h69 : 8'h96;
      @(posedge clk_sys_i);
      bit_clks <= 7'h20;
      apb(1, CTRL, ctl);
      prev = uart9_partner_i.frame_count;
      apb(1, BUF, {24'h0, dat});
      for (int n = 0; n < 1200 && uart9_partner_i.frame_count == prev; n++) begin
        @(posedge clk_sys_i);
      end
      check_word("rate tx frame", {21'h0, 2'b10, dat, 1'b0}, {21'h0, uart9_partner_i.frame_bits});
      uart9_partner_i.send_frame(~dat, 1'b1);
      apb(0, BUF, 0);
      check_word("rate rx data", {24'h0, ~dat}, rd);
    end
  endtask

  initial begin
    repeat (8) @(posedge clk_sys_i);
    resetn_i <= 1'b1;
    test_reset_values();
    test_tx();
    test_rx();
    test_filter();
    test_rates();
    give_verdict();
  end

  initial begin
    repeat (20000) @(posedge clk_sys_i);
    err_count++;
    give_verdict();
  end
endmodule // testbench
